// *** logic/rszc_top.sv ***
/*
 * Resizer source control: register bank, processing window, memory request
 * pacing, line interrupts and luma/chroma clamp.
 * Assumes pixel and sync inputs synchronous to core_clk_i and one pixel per cycle.
 */
`default_nettype none
module rszc_top #(
    parameter int HCNT_W = 16,
    parameter int VCNT_W = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire rszc_pkg::rszc_bus_t bus_i,
    output logic [31:0] rdata_o,
    input wire rszc_pkg::rszc_pix_t pipe_i,
    input wire rszc_pkg::rszc_pix_t prep_i,
    input wire logic cha_line_done_i,
    input wire logic chb_line_done_i,
    input wire logic cha_req_want_i,
    input wire logic chb_req_want_i,
    output rszc_pkg::rszc_out_t pix_o,
    output logic [1:0] mode_o,
    output logic chroma_420_o,
    output logic plane_sel_o,
    output logic raw_flip_o,
    output logic chroma_pos_o,
    output logic reg_clk_en_o,
    output logic core_clk_en_o,
    output logic cha_enable_o,
    output logic chb_enable_o,
    output logic cha_req_o,
    output logic chb_req_o,
    output logic cha_irq_o,
    output logic chb_irq_o,
    output logic status_o
);
    typedef struct packed {
        logic source_enable_reg;
        logic one_shot;
        logic wrt;
        logic bypass;
        logic src_sel;
        logic col;
        logic fmt420;
        logic raw;
        logic [15:0] vstart;
        logic [12:0] vsize;
        logic [15:0] hstart;
        logic [12:0] hsize;
        logic [7:0] gap_a;
        logic [7:0] gap_b;
        logic reg_gate;
        logic core_gate;
        logic [12:0] irq_a;
        logic [12:0] irq_b;
        logic [7:0] y_floor;
        logic [7:0] y_ceil;
        logic [7:0] c_floor;
        logic [7:0] c_ceil;
        logic c_pos;
        logic cha_en;
        logic chb_en;
        rszc_pkg::rszc_state_t state;
        logic fs_prev;
        logic ls_prev;
        logic [HCNT_W-1:0] pix_cnt;
        logic [VCNT_W-1:0] line_cnt;
        logic [12:0] lines_done;
        logic [7:0] gap_cnt_a;
        logic [7:0] gap_cnt_b;
        logic [12:0] irq_cnt_a;
        logic [12:0] irq_cnt_b;
        logic [31:0] rdata;
        rszc_pkg::rszc_out_t pix;
        logic req_a;
        logic req_b;
        logic irq_a_p;
        logic irq_b_p;
        rszc_pkg::rszc_mode_t mode;
        logic plane;
        logic status;
    } rszc_regs_t;

    rszc_regs_t st_q;
    rszc_regs_t st_d;

    function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
        if (v < lo) begin
            clamp8 = lo;
        end else if (v > hi) begin
            clamp8 = hi;
        end else begin
            clamp8 = v;
        end
    endfunction : clamp8

    function automatic logic [31:0] zext(input logic [15:0] v);
        zext = {16'h0000, v};
    endfunction : zext

    rszc_pkg::rszc_pix_t src;
    rszc_pkg::rszc_mode_t mode;
    logic fs_rise;
    logic ls_rise;
    logic in_h;
    logic in_v;
    logic last_line;
    logic wr_ok;

    always_comb begin
        src = st_q.src_sel ? prep_i : pipe_i;
        fs_rise = src.frame_sync && !st_q.fs_prev;
        ls_rise = src.line_sync && !st_q.ls_prev;
        // Core gate off forces the interpolator out of the path
        if (st_q.core_gate) begin
            mode = rszc_pkg::RSZC_RESCALE;
        end else if (st_q.bypass) begin
            mode = rszc_pkg::RSZC_PASS_THRU;
        end else begin
            mode = rszc_pkg::RSZC_RSZ_BYPASS;
        end
        in_v = (st_q.line_cnt >= st_q.vstart) && (st_q.lines_done <= st_q.vsize);
        in_h = (st_q.pix_cnt >= st_q.hstart)
            && ((st_q.pix_cnt - st_q.hstart) <= HCNT_W'(st_q.hsize));
        last_line = st_q.lines_done == st_q.vsize;
        wr_ok = bus_i.wr && st_q.reg_gate;
    end

    always_comb begin
        st_d = st_q;
        st_d.fs_prev = src.frame_sync;
        st_d.ls_prev = src.line_sync;
        st_d.mode = mode;
        st_d.irq_a_p = 1'b0;
        st_d.irq_b_p = 1'b0;
        st_d.req_a = 1'b0;
        st_d.req_b = 1'b0;

        // Counters clear on sync rising edges
        if (ls_rise) begin
            st_d.pix_cnt = '0;
        end else begin
            st_d.pix_cnt = st_q.pix_cnt + HCNT_W'(1);
        end
        if (fs_rise) begin
            st_d.line_cnt = '0;
        end else if (ls_rise) begin
            st_d.line_cnt = st_q.line_cnt + VCNT_W'(1);
        end

        unique case (st_q.state)
            rszc_pkg::RSZC_IDLE: begin
                if (st_q.source_enable_reg && fs_rise) begin
                    st_d.state = rszc_pkg::RSZC_RUN;
                    st_d.lines_done = '0;
                end
            end
            rszc_pkg::RSZC_RUN: begin
                // A line counts as done at the sync that ends it
                if (ls_rise && st_q.line_cnt >= st_q.vstart) begin
                    st_d.lines_done = st_q.lines_done + 13'h0001;
                    if (last_line) begin
                        st_d.state = rszc_pkg::RSZC_IDLE;
                        if (st_q.one_shot) begin
                            st_d.source_enable_reg = 1'b0;
                        end
                    end
                end
            end
            default: st_d.state = rszc_pkg::RSZC_IDLE;
        endcase

        st_d.pix.active = (st_q.state == rszc_pkg::RSZC_RUN) && in_v && in_h;
        st_d.pix.luma = clamp8(src.luma, st_q.y_floor, st_q.y_ceil);
        st_d.pix.chroma = clamp8(src.chroma, st_q.c_floor, st_q.c_ceil);

        // Request pacing: a new request only once the gap has run out
        if (st_q.gap_cnt_a != rszc_pkg::ZERO8) begin
            st_d.gap_cnt_a = st_q.gap_cnt_a - 8'h01;
        end else if (cha_req_want_i && st_q.cha_en) begin
            st_d.req_a = 1'b1;
            st_d.gap_cnt_a = st_q.gap_a;
        end
        if (st_q.gap_cnt_b != rszc_pkg::ZERO8) begin
            st_d.gap_cnt_b = st_q.gap_cnt_b - 8'h01;
        end else if (chb_req_want_i && st_q.chb_en) begin
            st_d.req_b = 1'b1;
            st_d.gap_cnt_b = st_q.gap_b;
        end

        if (cha_line_done_i) begin
            if (st_q.irq_cnt_a >= st_q.irq_a) begin
                st_d.irq_cnt_a = '0;
                st_d.irq_a_p = 1'b1;
            end else begin
                st_d.irq_cnt_a = st_q.irq_cnt_a + 13'h0001;
            end
        end
        if (chb_line_done_i) begin
            if (st_q.irq_cnt_b >= st_q.irq_b) begin
                st_d.irq_cnt_b = '0;
                st_d.irq_b_p = 1'b1;
            end else begin
                st_d.irq_cnt_b = st_q.irq_cnt_b + 13'h0001;
            end
        end

        // Always-writable group, even with the register clock gated
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                rszc_pkg::OFF_SOURCE_ENABLE_REG: st_d.source_enable_reg = bus_i.wdata[0];
                rszc_pkg::OFF_REG_GATE: st_d.reg_gate = bus_i.wdata[0];
                rszc_pkg::OFF_CORE_GATE: st_d.core_gate = bus_i.wdata[0];
                rszc_pkg::OFF_CHA_EN: st_d.cha_en = bus_i.wdata[0];
                rszc_pkg::OFF_CHB_EN: st_d.chb_en = bus_i.wdata[0];
                default: ;
            endcase
        end
        if (wr_ok) begin
            unique case (bus_i.addr)
                rszc_pkg::OFF_MODE: begin
                    st_d.one_shot = bus_i.wdata[0];
                    st_d.wrt = bus_i.wdata[1];
                end
                rszc_pkg::OFF_FMT_CTRL: begin
                    st_d.src_sel = bus_i.wdata[0];
                    st_d.bypass = bus_i.wdata[1];
                end
                rszc_pkg::OFF_FMT_SEL: begin
                    st_d.raw = bus_i.wdata[0];
                    st_d.fmt420 = bus_i.wdata[1];
                    st_d.col = bus_i.wdata[2];
                end
                rszc_pkg::OFF_VSTART: st_d.vstart = bus_i.wdata[15:0];
                rszc_pkg::OFF_VSIZE: st_d.vsize = bus_i.wdata[12:0];
                rszc_pkg::OFF_HSTART: st_d.hstart = bus_i.wdata[15:0];
                rszc_pkg::OFF_HSIZE: st_d.hsize = {bus_i.wdata[12:1], st_q.hsize[0]};
                rszc_pkg::OFF_GAP_A: st_d.gap_a = bus_i.wdata[7:0];
                rszc_pkg::OFF_GAP_B: st_d.gap_b = bus_i.wdata[7:0];
                rszc_pkg::OFF_IRQ_A: st_d.irq_a = bus_i.wdata[12:0];
                rszc_pkg::OFF_IRQ_B: st_d.irq_b = bus_i.wdata[12:0];
                rszc_pkg::OFF_Y_FLOOR: st_d.y_floor = bus_i.wdata[7:0];
                rszc_pkg::OFF_Y_CEIL: st_d.y_ceil = bus_i.wdata[7:0];
                rszc_pkg::OFF_C_FLOOR: st_d.c_floor = bus_i.wdata[7:0];
                rszc_pkg::OFF_C_CEIL: st_d.c_ceil = bus_i.wdata[7:0];
                rszc_pkg::OFF_C_POS: st_d.c_pos = bus_i.wdata[0];
                default: ;
            endcase
        end

        // Derived outputs are registered with the state they come from
        st_d.plane = st_d.fmt420 & st_d.col;
        st_d.status = st_d.state == rszc_pkg::RSZC_RUN;

        // Reads always allowed; unmapped offsets read zero
        st_d.rdata = '0;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                rszc_pkg::OFF_SOURCE_ENABLE_REG: st_d.rdata = zext({15'h0000, st_q.source_enable_reg});
                rszc_pkg::OFF_MODE: st_d.rdata = zext({14'h0000, st_q.wrt, st_q.one_shot});
                rszc_pkg::OFF_FMT_CTRL: st_d.rdata = zext({14'h0000, st_q.bypass, st_q.src_sel});
                rszc_pkg::OFF_FMT_SEL: st_d.rdata = zext({13'h0000, st_q.col, st_q.fmt420,
                                                          st_q.raw});
                rszc_pkg::OFF_VSTART: st_d.rdata = zext(st_q.vstart);
                rszc_pkg::OFF_VSIZE: st_d.rdata = zext({3'h0, st_q.vsize});
                rszc_pkg::OFF_HSTART: st_d.rdata = zext(st_q.hstart);
                rszc_pkg::OFF_HSIZE: st_d.rdata = zext({3'h0, st_q.hsize});
                rszc_pkg::OFF_GAP_A: st_d.rdata = zext({8'h00, st_q.gap_a});
                rszc_pkg::OFF_GAP_B: st_d.rdata = zext({8'h00, st_q.gap_b});
                rszc_pkg::OFF_STATUS: st_d.rdata = zext({15'h0000,
                    st_q.state == rszc_pkg::RSZC_RUN});
                rszc_pkg::OFF_REG_GATE: st_d.rdata = zext({15'h0000, st_q.reg_gate});
                rszc_pkg::OFF_CORE_GATE: st_d.rdata = zext({15'h0000, st_q.core_gate});
                rszc_pkg::OFF_IRQ_A: st_d.rdata = zext({3'h0, st_q.irq_a});
                rszc_pkg::OFF_IRQ_B: st_d.rdata = zext({3'h0, st_q.irq_b});
                rszc_pkg::OFF_Y_FLOOR: st_d.rdata = zext({8'h00, st_q.y_floor});
                rszc_pkg::OFF_Y_CEIL: st_d.rdata = zext({8'h00, st_q.y_ceil});
                rszc_pkg::OFF_C_FLOOR: st_d.rdata = zext({8'h00, st_q.c_floor});
                rszc_pkg::OFF_C_CEIL: st_d.rdata = zext({8'h00, st_q.c_ceil});
                rszc_pkg::OFF_C_POS: st_d.rdata = zext({15'h0000, st_q.c_pos});
                rszc_pkg::OFF_CHA_EN: st_d.rdata = zext({15'h0000, st_q.cha_en});
                rszc_pkg::OFF_CHB_EN: st_d.rdata = zext({15'h0000, st_q.chb_en});
                default: st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '0;
            st_q.hsize <= rszc_pkg::HSIZE_RST;
            st_q.irq_a <= rszc_pkg::IRQ_RST;
            st_q.irq_b <= rszc_pkg::IRQ_RST;
            st_q.y_ceil <= rszc_pkg::Y_CEIL_RST;
            st_q.c_ceil <= rszc_pkg::C_CEIL_RST;
            st_q.state <= rszc_pkg::RSZC_IDLE;
            st_q.mode <= rszc_pkg::RSZC_RSZ_BYPASS;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_o = st_q.rdata;
    assign pix_o = st_q.pix;
    assign mode_o = st_q.mode;
    assign chroma_420_o = st_q.fmt420;
    assign plane_sel_o = st_q.plane;
    assign raw_flip_o = st_q.raw;
    assign chroma_pos_o = st_q.c_pos;
    assign reg_clk_en_o = st_q.reg_gate;
    assign core_clk_en_o = st_q.core_gate;
    assign cha_enable_o = st_q.cha_en;
    assign chb_enable_o = st_q.chb_en;
    assign cha_req_o = st_q.req_a;
    assign chb_req_o = st_q.req_b;
    assign cha_irq_o = st_q.irq_a_p;
    assign chb_irq_o = st_q.irq_b_p;
    assign status_o = st_q.status;
endmodule : rszc_top
`default_nettype wire

// *** logic/rszc_pkg.sv ***
/*
 * Package for the resizer source control block: register offsets, field widths,
 * reset values, mode encodings and the carrier structs.
 * Assumes a single core clock and a plain register port with one-cycle read latency.
 */
// Function
// - Source-select 1 takes pixels from preprocessor interface, 0 from image pipe.
// - Bypass field 1 enables pass-through, skipping all image processing; here core gate 1 overrides it and gives rescale, clamp still applies.
// - Chroma-format bit 0 means 4:2:2 input, 1 means 4:2:0 input.
// - Plane-select bit 2 is honoured only for 4:2:0 input.
// - Pass-through flipping keeps YCbCr order when raw bit 0, Bayer order when 1.
// - Processing starts at vertical start line counted from frame-sync rise.
// - Exactly vertical size plus one lines are processed.
// - Each line starts at horizontal start pixel counted from line-sync rise.
// - Horizontal size plus one pixels; resets to 1, bit 0 not writable.
// - Per channel, memory requests spaced by at least the interval field cycles.
// - Read-only status bit 0 shows process state, resets to 0.
// - With register clock gate 0, only enables and clock gates accept writes.
// - Core clock gate 0 bypasses the interpolator core.
// - Mode: rescale, resizer-bypass or pass-through from core gate and bypass.
// - Per channel, interrupt every interval plus one output lines; resets 8191.
// - Luma saturates between floor and ceiling; ceiling 255, floor 0.
// - Chroma saturates between chroma floor and chroma ceiling.
// - Enable starts processing at next frame-sync rise; one-shot clears it after.
// - One-shot bit 0 runs continuously, 1 processes a single frame.
package rszc_pkg;
    localparam int ADDR_W = 9;
    localparam logic [8:0] OFF_SOURCE_ENABLE_REG = 9'h000;
    localparam logic [8:0] OFF_MODE = 9'h004;
    localparam logic [8:0] OFF_FMT_CTRL = 9'h008;
    localparam logic [8:0] OFF_FMT_SEL = 9'h00C;
    localparam logic [8:0] OFF_VSTART = 9'h010;
    localparam logic [8:0] OFF_VSIZE = 9'h014;
    localparam logic [8:0] OFF_HSTART = 9'h018;
    localparam logic [8:0] OFF_HSIZE = 9'h01C;
    localparam logic [8:0] OFF_GAP_A = 9'h020;
    localparam logic [8:0] OFF_GAP_B = 9'h024;
    localparam logic [8:0] OFF_STATUS = 9'h028;
    localparam logic [8:0] OFF_REG_GATE = 9'h02C;
    localparam logic [8:0] OFF_CORE_GATE = 9'h030;
    localparam logic [8:0] OFF_IRQ_A = 9'h034;
    localparam logic [8:0] OFF_IRQ_B = 9'h038;
    localparam logic [8:0] OFF_Y_FLOOR = 9'h03C;
    localparam logic [8:0] OFF_Y_CEIL = 9'h040;
    localparam logic [8:0] OFF_C_FLOOR = 9'h044;
    localparam logic [8:0] OFF_C_CEIL = 9'h048;
    localparam logic [8:0] OFF_C_POS = 9'h050;
    localparam logic [8:0] OFF_CHA_EN = 9'h058;
    localparam logic [8:0] OFF_CHB_EN = 9'h0E8;

    localparam logic [12:0] HSIZE_RST = 13'h0001;
    localparam logic [12:0] IRQ_RST = 13'h1FFF;
    localparam logic [7:0] Y_CEIL_RST = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] C_CEIL_RST = 8'hFF;

    typedef enum logic [1:0] {
        RSZC_RESCALE = 2'b00,
        RSZC_RSZ_BYPASS = 2'b01,
        RSZC_PASS_THRU = 2'b10
    } rszc_mode_t;

    typedef enum logic [1:0] {
        RSZC_IDLE = 2'b00,
        RSZC_ARMED = 2'b01,
        RSZC_RUN = 2'b10
    } rszc_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rszc_bus_t;

    typedef struct packed {
        logic frame_sync;
        logic line_sync;
        logic [7:0] luma;
        logic [7:0] chroma;
    } rszc_pix_t;

    typedef struct packed {
        logic active;
        logic [7:0] luma;
        logic [7:0] chroma;
    } rszc_out_t;
endpackage : rszc_pkg

// *** tb/rszc_chk.sv ***
/* Port-level assertions for rszc_top: mode, plane select, request and interrupt causes, status.
   Assumes one core clock and the active-high asynchronous reset of the top module. */
`default_nettype none
module rszc_chk (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire rszc_pkg::rszc_bus_t bus_i,
    input wire logic [31:0] rdata_o,
    input wire rszc_pkg::rszc_pix_t pipe_i,
    input wire rszc_pkg::rszc_pix_t prep_i,
    input wire logic cha_line_done_i,
    input wire logic chb_line_done_i,
    input wire logic cha_req_want_i,
    input wire logic chb_req_want_i,
    input wire logic [1:0] mode_o,
    input wire logic chroma_420_o,
    input wire logic plane_sel_o,
    input wire logic core_clk_en_o,
    input wire logic cha_enable_o,
    input wire logic chb_enable_o,
    input wire logic cha_req_o,
    input wire logic chb_req_o,
    input wire logic cha_irq_o,
    input wire logic chb_irq_o,
    input wire logic status_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // One cycle of settling allowed, since mode is registered from the gate register
    a_core_on_rescale: assert property (
        core_clk_en_o && $past(core_clk_en_o) |-> mode_o == 2'h0)
        else $error("rescale expected while core clock runs");
    a_core_off_bypass: assert property (
        !core_clk_en_o && !$past(core_clk_en_o) |-> mode_o != 2'h0)
        else $error("interpolator not bypassed with core clock off");
    a_plane_needs_420: assert property (plane_sel_o |-> chroma_420_o)
        else $error("plane select honoured outside 4:2:0");
    a_req_a_cause: assert property (
        cha_req_o |-> $past(cha_req_want_i) && $past(cha_enable_o))
        else $error("channel a request without cause");
    a_req_b_cause: assert property (
        chb_req_o |-> $past(chb_req_want_i) && $past(chb_enable_o))
        else $error("channel b request without cause");
    a_irq_a_cause: assert property (cha_irq_o |-> $past(cha_line_done_i))
        else $error("channel a interrupt without line end");
    a_irq_b_cause: assert property (chb_irq_o |-> $past(chb_line_done_i))
        else $error("channel b interrupt without line end");
    a_status_on_frame: assert property ($rose(status_o) |->
        $past(pipe_i.frame_sync) || $past(prep_i.frame_sync))
        else $error("status rose without frame sync");
    a_rdata_quiet: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0)
        else $error("read data outside read answer cycle");
    c_frame_done: cover property ($fell(status_o));
    c_irq_a: cover property (cha_irq_o);
    c_pass_thru: cover property (mode_o == 2'h2);
endmodule : rszc_chk
bind rszc_top rszc_chk i_rszc_chk (.core_clk_i, .rst_i, .bus_i, .rdata_o, .pipe_i, .prep_i,
    .cha_line_done_i, .chb_line_done_i, .cha_req_want_i, .chb_req_want_i, .mode_o,
    .chroma_420_o, .plane_sel_o, .core_clk_en_o, .cha_enable_o, .chb_enable_o, .cha_req_o,
    .chb_req_o, .cha_irq_o, .chb_irq_o, .status_o);
`default_nettype wire

// *** tb/rszc_src_model.sv ***
/* Upstream pixel source: frame sync over the first line, line sync for two cycles a line.
   Assumes one pixel per clock; syncs stay low while run_i is low. */
`default_nettype none
module rszc_src_model #(
    parameter int LINE_LEN = 32,
    parameter int NUM_LINES = 8,
    parameter int SEED = 92628
) (
    input wire logic clk_i,
    input wire logic run_i,
    output rszc_pkg::rszc_pix_t pix_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int px = 0;
    int ln = 0;
    int seed = SEED;
    initial pix_o = '0;
    // Samples are redrawn every cycle so a stale value matches by luck only about once in 256
    always @(posedge clk_i) begin
        pix_o.luma <= 8'($random(seed));
        pix_o.chroma <= 8'($random(seed));
        pix_o.frame_sync <= run_i && ln == 0;
        pix_o.line_sync <= run_i && px < 2;
        if (run_i) begin
            px <= (px == LINE_LEN - 1) ? 0 : px + 1;
            if (px == LINE_LEN - 1) ln <= (ln == NUM_LINES - 1) ? 0 : ln + 1;
        end
    end
endmodule : rszc_src_model
`default_nettype wire

// *** tb/tb_top.sv ***
/* Self-checking bench for rszc_top: registers, modes, request pacing, interrupts, two one-shot frames.
   Assumes two source models on the pixel inputs and a 20 MHz core clock. */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [8:0] WA [8] = '{rszc_pkg::OFF_VSTART, rszc_pkg::OFF_VSIZE,
        rszc_pkg::OFF_HSTART, rszc_pkg::OFF_GAP_A, rszc_pkg::OFF_GAP_B, rszc_pkg::OFF_IRQ_A,
        rszc_pkg::OFF_IRQ_B, rszc_pkg::OFF_C_POS};
    localparam logic [31:0] WM [8] = '{32'hFFFF, 32'h1FFF, 32'hFFFF, 32'hFF, 32'hFF, 32'h1FFF,
        32'h1FFF, 32'h1};
    logic core_clk_i = 1'b0, rst_i = 1'b1, run = 1'b0, use_prep = 1'b0;
    logic done_a = 1'b0, done_b = 1'b0, want_a = 1'b0, want_b = 1'b0;
    rszc_pkg::rszc_bus_t bus_i = '0;
    rszc_pkg::rszc_pix_t pipe_i, prep_i;
    rszc_pkg::rszc_out_t pix_o;
    logic [31:0] rdata_o, d, w;
    logic [1:0] mode_o;
    logic c420, psel, rflip, rgate, cgate, en_a, en_b, req_a, req_b, irq_a, irq_b, status_o, cpos;
    logic [7:0] yf = 8'h00, yc = 8'hFF, cf = 8'h00, cc = 8'hFF, py = 8'h00, pc = 8'h00;
    int num_errors = 0, tests_run = 0, seed = 92628, cycles = 0, act_n = 0;
    int i, n, last, cnt, g;

    rszc_top i_rszc_top (.core_clk_i, .rst_i, .bus_i, .rdata_o, .pipe_i, .prep_i,
        .cha_line_done_i(done_a), .chb_line_done_i(done_b), .cha_req_want_i(want_a),
        .chb_req_want_i(want_b), .pix_o, .mode_o, .chroma_420_o(c420), .plane_sel_o(psel),
        .raw_flip_o(rflip), .chroma_pos_o(cpos), .reg_clk_en_o(rgate), .core_clk_en_o(cgate),
        .cha_enable_o(en_a), .chb_enable_o(en_b), .cha_req_o(req_a), .chb_req_o(req_b),
        .cha_irq_o(irq_a), .chb_irq_o(irq_b), .status_o);
    rszc_src_model #(.SEED(92629)) i_pipe_src (.clk_i(core_clk_i), .run_i(run), .pix_o(pipe_i));
    rszc_src_model #(.SEED(92630)) i_prep_src (.clk_i(core_clk_i), .run_i(run), .pix_o(prep_i));

    initial forever #25 core_clk_i = ~core_clk_i;

    task automatic stop_test();
        $display("errors %0d comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [8:0] a, input logic [31:0] v);
        @(posedge core_clk_i);
        bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        bus_i.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a, output logic [31:0] v);
        @(posedge core_clk_i);
        bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        bus_i.rd <= 1'b0;
        @(negedge core_clk_i);
        v = rdata_o;
    endtask : rd

    task automatic wst(input logic v);
        for (int k = 0; k < 600 && status_o !== v; k++) @(negedge core_clk_i);
        cmp(32'(status_o), 32'(v));
    endtask : wst

    function automatic logic [31:0] rv(input logic [8:0] a);
        case (a)
            rszc_pkg::OFF_HSIZE: return 32'h1;
            rszc_pkg::OFF_IRQ_A, rszc_pkg::OFF_IRQ_B: return 32'h1FFF;
            rszc_pkg::OFF_Y_CEIL, rszc_pkg::OFF_C_CEIL: return 32'hFF;
            default: return 32'h0;
        endcase
    endfunction : rv

    function automatic logic [7:0] clip(input logic [7:0] v, input logic [7:0] f, c);
        return (v < f) ? f : (v > c) ? c : v;
    endfunction : clip

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            stop_test();
        end
    end

    // Output lags input by one cycle, so the expectation uses last cycle's sample
    always @(posedge core_clk_i) begin
        if (!rst_i && pix_o.active === 1'b1) begin
            act_n++;
            cmp(32'(pix_o.luma), 32'(clip(py, yf, yc)));
            cmp(32'(pix_o.chroma), 32'(clip(pc, cf, cc)));
        end
        py = use_prep ? prep_i.luma : pipe_i.luma;
        pc = use_prep ? prep_i.chroma : pipe_i.chroma;
    end

    initial begin
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 32'h60; i += 4) begin
            rd(9'(i), d);
            cmp(d, rv(9'(i)));
        end
        wr(rszc_pkg::OFF_VSTART, 32'h5);
        rd(rszc_pkg::OFF_VSTART, d);
        cmp(d, 32'h0);
        wr(rszc_pkg::OFF_CHA_EN, 32'h1);
        wr(rszc_pkg::OFF_CHB_EN, 32'h1);
        wr(rszc_pkg::OFF_REG_GATE, 32'h1);
        rd(rszc_pkg::OFF_CHB_EN, d);
        cmp({d[28:0], en_b, en_a, rgate}, 32'hF);
        for (i = 0; i < 32; i++) begin
            w = $random(seed) & WM[i % 8];
            wr(WA[i % 8], w);
            rd(WA[i % 8], d);
            cmp(d, w);
            if (WA[i % 8] == rszc_pkg::OFF_C_POS) cmp(32'(cpos), w);
            w = (i == 0) ? 32'h0 : $random(seed) & 32'h1FFF;
            wr(rszc_pkg::OFF_HSIZE, w);
            rd(rszc_pkg::OFF_HSIZE, d);
            cmp(d, w & 32'h1FFE | 32'h1);
        end
        for (i = 0; i < 4; i++) begin
            wr(rszc_pkg::OFF_CORE_GATE, 32'(i / 2));
            wr(rszc_pkg::OFF_FMT_CTRL, 32'((i % 2) * 2));
            repeat (3) @(negedge core_clk_i);
            cmp({29'h0, cgate, mode_o},
                (i > 1) ? 32'h4 : (i == 1) ? 32'h2 : 32'h1);
        end
        for (i = 0; i < 8; i++) begin
            wr(rszc_pkg::OFF_FMT_SEL, 32'(i));
            repeat (3) @(negedge core_clk_i);
            cmp({29'h0, c420, psel, rflip},
                {29'h0, i[1], i[1] & i[2], i[0]});
        end
        for (i = 0; i < 2; i++) begin
            g = (i == 0) ? 0 : ($random(seed) & 7) | 1;
            wr(i ? rszc_pkg::OFF_GAP_B : rszc_pkg::OFF_GAP_A, 32'(g));
            @(posedge core_clk_i);
            if (i) want_b <= 1'b1;
            else want_a <= 1'b1;
            last = -1;
            cnt = 0;
            for (n = 0; n < 60; n++) begin
                @(negedge core_clk_i);
                if ((i ? req_b : req_a) === 1'b1) begin
                    if (last >= 0) cmp(32'(n - last), 32'(g + 1));
                    last = n;
                    cnt++;
                end
            end
            @(posedge core_clk_i);
            want_a <= 1'b0;
            want_b <= 1'b0;
            cmp(32'(cnt > 3), 32'h1);
        end
        wr(rszc_pkg::OFF_IRQ_A, 32'h2);
        wr(rszc_pkg::OFF_IRQ_B, 32'h3);
        n = 0;
        cnt = 0;
        for (i = 0; i < 27; i++) begin
            @(posedge core_clk_i);
            done_a <= (i % 3 == 0);
            done_b <= (i % 3 == 0);
            @(negedge core_clk_i);
            n += (irq_a === 1'b1);
            cnt += (irq_b === 1'b1);
        end
        cmp({n[15:0], cnt[15:0]}, 32'h30002);
        wr(rszc_pkg::OFF_VSTART, 32'h2);
        wr(rszc_pkg::OFF_VSIZE, 32'h1);
        wr(rszc_pkg::OFF_HSTART, 32'h3);
        wr(rszc_pkg::OFF_HSIZE, 32'h5);
        wr(rszc_pkg::OFF_MODE, 32'h1);
        // Second frame is raw pass-through from the pipe, so the clamp is opened
        for (g = 0; g < 2; g++) begin
            yf = g ? 8'h00 : 8'h20;
            yc = g ? 8'hFF : 8'hD0;
            cf = g ? 8'h00 : 8'h30;
            cc = g ? 8'hFF : 8'hC0;
            wr(rszc_pkg::OFF_Y_FLOOR, 32'(yf));
            wr(rszc_pkg::OFF_Y_CEIL, 32'(yc));
            wr(rszc_pkg::OFF_C_FLOOR, 32'(cf));
            wr(rszc_pkg::OFF_C_CEIL, 32'(cc));
            wr(rszc_pkg::OFF_FMT_SEL, 32'(g));
            wr(rszc_pkg::OFF_CORE_GATE, 32'(1 - g));
            wr(rszc_pkg::OFF_FMT_CTRL, g ? 32'h2 : 32'h1);
            wr(rszc_pkg::OFF_SOURCE_ENABLE_REG, 32'h1);
            use_prep = (g == 0);
            act_n = 0;
            @(posedge core_clk_i);
            run <= 1'b1;
            wst(1'b1);
            rd(rszc_pkg::OFF_STATUS, d);
            cmp(d, 32'h1);
            wst(1'b0);
            @(posedge core_clk_i);
            run <= 1'b0;
            cmp(32'(act_n), 32'h0C);
            rd(rszc_pkg::OFF_SOURCE_ENABLE_REG, d);
            cmp(d, 32'h0);
        end
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
